/* core/tip_port_top.sv */
// five timed i/o ports (1/4/8/16/32 bits) over 32 shared pins, six clock blocks
// assumes pin, ready and link inputs synchronous to CLOCK_I; avalon-mm slave
// Summary of operation
// (R1) ports of width 1, 4, 8, 16 and 32 bits over shared pins
// (R2) a port's direction is one bit for all its pins
// (R3) ports drive or sample pins, optionally waiting for an equal/unequal match; only input ports wait, output ports ignore the condition
// (R4) each register access answers in two clock cycles unless data must wait
// (R5) open-drain option per port: drive low for zero, release for one
// (R6) data passes through a shift stage and a transfer register
// (R7) each port has a 16-bit counter gating pin transfers
// (R8) counter readable always; a transfer can wait for a counter value
// (R9) counter value captured as timestamp at each word transfer
// (R10) pin events pulse an event output to the processor
// (R11) enabled link disables port drive on the link's pins
// (R12) narrowest enabled port owns a shared pin; others keep unshared pins
// (R13) every input port samples at its full width regardless of sharing; an output port drives only the pins it owns
// (R14) six clock blocks; block 0 is the fixed 100 MHz reference tick
// (R15) a clock block may take pin 0 as its clock source
// (R16) a clock block can divide its source
// (R17) ready input gates transfers; strobe out accompanies output data
// (R18) after reset every port uses clock block 0
// (R19) pull-downs on all pins while reset is held
// (R20) an output port holds its last value until the next transfer
// (R21) counter steps once per tick of its port's clock block while the port is enabled, wrapping at its maximum
`timescale 1ns/100ps
module tip_port_top (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic [9:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [31:0] PIN_I,
  output logic [31:0] PIN_O,
  output logic [31:0] PIN_OE_O,
  output logic [31:0] PULLDOWN_O,
  input wire logic [31:0] LINK_O_I,
  input wire logic [31:0] LINK_OE_I,
  input wire logic [4:0] READY_I,
  output logic [4:0] STROBE_OUT_O,
  output logic [4:0] EVENT_O
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [5:0] port_width(input int k);
    case (k)
      0: port_width = 6'h01;
      1: port_width = 6'h04;
      2: port_width = 6'h08;
      3: port_width = 6'h10;
      default: port_width = 6'h20;
    endcase
  endfunction

  function automatic logic [31:0] width_mask(input int k);
    logic [32:0] m;
    m = (33'h1 << port_width(k)) - 33'h1;
    width_mask = m[31:0];
  endfunction

  function automatic logic [5:0] slices(input int k);
    slices = 6'(32 / int'(port_width(k)));
  endfunction

  // new slice enters at the top so the first sample ends in the low bits
  function automatic logic [31:0] shift_in(input int k, input logic [31:0] sh,
                                           input logic [31:0] pins);
    logic [63:0] cat;
    cat = {pins & width_mask(k), sh} >> port_width(k);
    shift_in = cat[31:0];
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    be_merge = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  tip_pkg::tip_port_cfg_t cfg_q [tip_pkg::NPORT];
  logic [31:0] cond_val_q [tip_pkg::NPORT];
  logic [31:0] tr_q [tip_pkg::NPORT];
  logic [31:0] sh_q [tip_pkg::NPORT];
  logic [31:0] pout_q [tip_pkg::NPORT];
  logic [5:0] shn_q [tip_pkg::NPORT];
  logic [15:0] cnt_q [tip_pkg::NPORT]; // [R7]
  logic [15:0] time_q [tip_pkg::NPORT];
  logic [15:0] ts_q [tip_pkg::NPORT];
  logic [4:0] tr_full_q;
  logic [4:0] armed_q;
  logic [4:0] cpend_q;
  logic [4:0] strobe_q;
  logic [4:0] ev_q;
  logic [tip_pkg::NCLK-1:0] cb_en_q;
  logic [tip_pkg::NCLK-1:0] cb_src_q;
  logic [7:0] cb_div_q [tip_pkg::NCLK];
  logic [7:0] cb_cnt_q [tip_pkg::NCLK];
  logic [tip_pkg::NCLK-1:0] cb_tick;
  logic [7:0] ref_acc_q;
  logic ref_tick_q;
  logic pin0_prev_q;
  logic link_en_q;
  logic pd_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [4:0] port_tick;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic req;
  logic do_bus;
  logic can_ack;
  logic [1:0] region;
  logic [2:0] pidx;
  logic [2:0] ridx;
  logic port_hit;
  logic clk_hit;
  logic link_hit;
  logic [31:0] rd_val;

  assign req = AVS_READ_I | AVS_WRITE_I;
  assign do_bus = req & ack_q;
  assign region = AVS_ADDRESS_I[9:8];
  assign pidx = AVS_ADDRESS_I[7:5];
  assign ridx = AVS_ADDRESS_I[4:2];
  assign port_hit = (region == tip_pkg::REGION_PORT) && (int'(pidx) < tip_pkg::NPORT);
  assign clk_hit = (region == tip_pkg::REGION_CLK) && (AVS_ADDRESS_I[7:5] == 3'h0)
                   && (int'(ridx) < tip_pkg::NCLK);
  assign link_hit = (AVS_ADDRESS_I[9:2] == tip_pkg::LINK_CTRL[9:2]);

  // data access stalls until the transfer register can take or give a word
  always_comb begin
    can_ack = 1'b1;
    if (port_hit && ridx == tip_pkg::REG_DATA) begin
      if (AVS_WRITE_I && cfg_q[pidx].out_dir && tr_full_q[pidx]) begin
        can_ack = 1'b0;
      end
      if (AVS_READ_I && !cfg_q[pidx].out_dir && !tr_full_q[pidx]) begin
        can_ack = 1'b0;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (port_hit) begin
      case (ridx)
        tip_pkg::REG_CTRL: rd_val = {{(32-tip_pkg::CTRL_W){1'b0}}, cfg_q[pidx]};
        tip_pkg::REG_COND: rd_val = cond_val_q[pidx];
        tip_pkg::REG_TIME: rd_val = {16'h0000, time_q[pidx]};
        tip_pkg::REG_DATA: rd_val = tr_q[pidx];
        tip_pkg::REG_STAT: begin
          rd_val[tip_pkg::STAT_FULL] = tr_full_q[pidx];
          rd_val[tip_pkg::STAT_SLICE_LO +: 6] = shn_q[pidx];
          rd_val[tip_pkg::STAT_ARMED] = armed_q[pidx];
          rd_val[tip_pkg::STAT_COND] = cpend_q[pidx];
        end
        tip_pkg::REG_COUNT: rd_val = {16'h0000, cnt_q[pidx]}; // [R8]
        tip_pkg::REG_TSTAMP: rd_val = {16'h0000, ts_q[pidx]}; // [R9]
        default: rd_val = 32'h0000_0000;
      endcase
    end else if (clk_hit) begin
      rd_val[tip_pkg::CB_EN] = cb_en_q[ridx];
      rd_val[tip_pkg::CB_SRC] = cb_src_q[ridx];
      rd_val[tip_pkg::CB_DIV_LO +: 8] = cb_div_q[ridx];
    end else if (link_hit) begin
      rd_val[0] = link_en_q;
    end
  end

  assign AVS_WAITREQUEST_O = req & ~ack_q; // [R4]
  assign AVS_READDATA_O = rdata_q;

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q & can_ack; // [R4]
      if (AVS_READ_I && !ack_q && can_ack) begin
        rdata_q <= rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock blocks

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ref_acc_q <= 8'h00;
      ref_tick_q <= 1'b0;
    end else if (ref_acc_q + tip_pkg::REF_INC >= tip_pkg::REF_MOD) begin
      ref_acc_q <= ref_acc_q + tip_pkg::REF_INC - tip_pkg::REF_MOD; // [R14]
      ref_tick_q <= 1'b1;
    end else begin
      ref_acc_q <= ref_acc_q + tip_pkg::REF_INC;
      ref_tick_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin0_prev_q <= 1'b0;
    end else begin
      pin0_prev_q <= PIN_I[0];
    end
  end

  always_comb begin
    for (int b = 0; b < tip_pkg::NCLK; b++) begin
      logic src;
      src = cb_src_q[b] ? (PIN_I[0] & ~pin0_prev_q) : ref_tick_q; // [R15]
      cb_tick[b] = cb_en_q[b] & src & (cb_cnt_q[b] == cb_div_q[b]); // [R16]
    end
    cb_tick[0] = ref_tick_q; // [R14]
  end

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cb_en_q <= 6'h01;
      cb_src_q <= 6'h00;
      for (int b = 0; b < tip_pkg::NCLK; b++) begin
        cb_div_q[b] <= 8'h00;
        cb_cnt_q[b] <= 8'h00;
      end
    end else begin
      for (int b = 1; b < tip_pkg::NCLK; b++) begin
        logic src;
        src = cb_src_q[b] ? (PIN_I[0] & ~pin0_prev_q) : ref_tick_q;
        if (cb_en_q[b] && src) begin
          cb_cnt_q[b] <= cb_tick[b] ? 8'h00 : cb_cnt_q[b] + 8'h01; // [R16]
        end
      end
      if (do_bus && AVS_WRITE_I && clk_hit && ridx != 3'h0) begin
        logic [31:0] w;
        w = be_merge(rd_val, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
        cb_en_q[ridx] <= w[tip_pkg::CB_EN];
        cb_src_q[ridx] <= w[tip_pkg::CB_SRC]; // [R15]
        cb_div_q[ridx] <= w[tip_pkg::CB_DIV_LO +: 8];
        cb_cnt_q[ridx] <= 8'h00;
      end
    end
  end

  always_comb begin
    for (int k = 0; k < tip_pkg::NPORT; k++) begin
      if (int'(cfg_q[k].clk_sel) < tip_pkg::NCLK) begin
        port_tick[k] = cfg_q[k].enable & cb_tick[cfg_q[k].clk_sel];
      end else begin
        port_tick[k] = cfg_q[k].enable & cb_tick[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port datapaths

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int k = 0; k < tip_pkg::NPORT; k++) begin
        cfg_q[k] <= tip_pkg::tip_port_cfg_t'(tip_pkg::CTRL_RESET[tip_pkg::CTRL_W-1:0]); // [R18]
        cond_val_q[k] <= 32'h0000_0000;
        tr_q[k] <= 32'h0000_0000;
        sh_q[k] <= 32'h0000_0000;
        pout_q[k] <= 32'h0000_0000;
        shn_q[k] <= 6'h00;
        cnt_q[k] <= 16'h0000;
        time_q[k] <= 16'h0000;
        ts_q[k] <= 16'h0000;
      end
      tr_full_q <= 5'h00;
      armed_q <= 5'h00;
      cpend_q <= 5'h00;
      strobe_q <= 5'h00;
      ev_q <= 5'h00;
    end else begin
      for (int k = 0; k < tip_pkg::NPORT; k++) begin
        logic start_ok;
        logic rdy_ok;
        logic match;
        logic [31:0] word;
        start_ok = ~armed_q[k] | (cnt_q[k] == time_q[k]); // [R8]
        rdy_ok = ~cfg_q[k].strobe_en | READY_I[k]; // [R17]
        match = ((PIN_I & width_mask(k)) == (cond_val_q[k] & width_mask(k)));
        if (cfg_q[k].cond_mode == tip_pkg::TIP_COND_NE) begin
          match = ~match;
        end
        word = shift_in(k, sh_q[k], PIN_I); // [R13]
        ev_q[k] <= 1'b0;
        if (port_tick[k]) begin
          cnt_q[k] <= cnt_q[k] + 16'h0001; // [R21]
          if (cfg_q[k].out_dir) begin
            strobe_q[k] <= 1'b0;
            if (shn_q[k] == 6'h00 && tr_full_q[k] && start_ok && rdy_ok) begin
              pout_q[k] <= tr_q[k] & width_mask(k); // [R6]
              sh_q[k] <= tr_q[k] >> port_width(k);
              shn_q[k] <= slices(k) - 6'h01;
              tr_full_q[k] <= 1'b0;
              ts_q[k] <= cnt_q[k]; // [R9]
              armed_q[k] <= 1'b0;
              ev_q[k] <= 1'b1; // [R10]
              strobe_q[k] <= 1'b1; // [R17]
            end else if (shn_q[k] != 6'h00 && rdy_ok) begin
              pout_q[k] <= sh_q[k] & width_mask(k); // [R6]
              sh_q[k] <= sh_q[k] >> port_width(k);
              shn_q[k] <= shn_q[k] - 6'h01;
              strobe_q[k] <= 1'b1;
            end
          end else if ((~cpend_q[k] | match) && start_ok && rdy_ok
                       && !(tr_full_q[k] && shn_q[k] == slices(k) - 6'h01)) begin
            cpend_q[k] <= 1'b0; // [R3]
            if (cpend_q[k]) begin
              ev_q[k] <= 1'b1;
            end
            if (shn_q[k] == slices(k) - 6'h01) begin
              tr_q[k] <= word; // [R6]
              tr_full_q[k] <= 1'b1;
              ts_q[k] <= cnt_q[k]; // [R9]
              armed_q[k] <= 1'b0;
              shn_q[k] <= 6'h00;
              ev_q[k] <= 1'b1; // [R10]
            end else begin
              sh_q[k] <= word;
              shn_q[k] <= shn_q[k] + 6'h01;
            end
          end
        end
        if (do_bus && port_hit && int'(pidx) == k) begin
          logic [31:0] w;
          w = be_merge(rd_val, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
          if (AVS_WRITE_I) begin
            case (ridx)
              tip_pkg::REG_CTRL: begin
                cfg_q[k] <= tip_pkg::tip_port_cfg_t'(w[tip_pkg::CTRL_W-1:0]); // [R2] [R5]
                cpend_q[k] <= (w[4:3] != 2'b00);
                shn_q[k] <= 6'h00;
              end
              tip_pkg::REG_COND: begin
                cond_val_q[k] <= w;
                cpend_q[k] <= (cfg_q[k].cond_mode != tip_pkg::TIP_COND_NONE); // [R3]
              end
              tip_pkg::REG_TIME: begin
                time_q[k] <= w[15:0];
                armed_q[k] <= 1'b1; // [R8]
              end
              tip_pkg::REG_DATA: begin
                if (cfg_q[k].out_dir) begin
                  tr_q[k] <= w;
                  tr_full_q[k] <= 1'b1;
                end
              end
              default: begin
              end
            endcase
          end else if (ridx == tip_pkg::REG_DATA && !cfg_q[k].out_dir) begin
            tr_full_q[k] <= 1'b0;
          end
        end
      end
    end
  end

  assign STROBE_OUT_O = strobe_q;
  assign EVENT_O = ev_q;

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership and drive

  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      link_en_q <= 1'b0;
      pd_q <= 1'b1; // [R19]
    end else begin
      pd_q <= 1'b0;
      if (do_bus && AVS_WRITE_I && link_hit && AVS_BYTEENABLE_I[0]) begin
        link_en_q <= AVS_WRITEDATA_I[0];
      end
    end
  end

  assign PULLDOWN_O = {32{pd_q}}; // [R19]

  always_comb begin
    for (int p = 0; p < tip_pkg::NPIN; p++) begin
      int own;
      own = -1;
      for (int k = tip_pkg::NPORT - 1; k >= 0; k--) begin
        if (cfg_q[k].enable && p < int'(port_width(k))) begin
          own = k; // [R12]
        end
      end
      PIN_O[p] = 1'b0;
      PIN_OE_O[p] = 1'b0;
      if (link_en_q && tip_pkg::LINK_PIN_MASK[p]) begin
        PIN_O[p] = LINK_O_I[p]; // [R11]
        PIN_OE_O[p] = LINK_OE_I[p];
      end else if (own >= 0 && cfg_q[own].out_dir) begin
        if (cfg_q[own].open_drain) begin
          PIN_OE_O[p] = ~pout_q[own][p]; // [R5]
        end else begin
          PIN_O[p] = pout_q[own][p]; // [R20]
          PIN_OE_O[p] = 1'b1; // [R1]
        end
      end
    end
  end

endmodule

/* shared/tip_pkg.sv */
// constants, field layouts and carrier types for the timed i/o port block
// assumes a 32-bit avalon-mm register bus with byte addresses
package tip_pkg;
  localparam int NPORT = 5;
  localparam int NCLK = 6;
  localparam int NPIN = 32;
  // reference tick rate against the system clock rate
  localparam int CLK_MHZ = 125;
  localparam int REF_MHZ = 100;
  localparam logic [7:0] REF_INC = 8'(REF_MHZ);
  localparam logic [7:0] REF_MOD = 8'(CLK_MHZ);
  // address map: [9:8] region, ports [7:5] index [4:2] register
  localparam logic [1:0] REGION_PORT = 2'h0;
  localparam logic [1:0] REGION_CLK = 2'h1;
  localparam logic [1:0] REGION_LINK = 2'h2;
  localparam logic [9:0] PORT_STRIDE = 10'h020;
  localparam logic [9:0] CLK_BASE = 10'h100;
  localparam logic [9:0] LINK_CTRL = 10'h200;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_COND = 3'h1;
  localparam logic [2:0] REG_TIME = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam logic [2:0] REG_STAT = 3'h4;
  localparam logic [2:0] REG_COUNT = 3'h5;
  localparam logic [2:0] REG_TSTAMP = 3'h6;
  // port control word, bits [8:0]
  localparam int CTRL_W = 9;
  // status word fields
  localparam int STAT_FULL = 0;
  localparam int STAT_SLICE_LO = 8;
  localparam int STAT_ARMED = 16;
  localparam int STAT_COND = 17;
  // clock block word fields
  localparam int CB_EN = 0;
  localparam int CB_SRC = 1;
  localparam int CB_DIV_LO = 8;
  // pins taken over by the inter-chip link when enabled
  localparam logic [31:0] LINK_PIN_MASK = 32'h0000_00F0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    TIP_COND_NONE = 2'b00,
    TIP_COND_EQ = 2'b01,
    TIP_COND_NE = 2'b10
  } tip_cond_t;

  typedef struct packed {
    logic strobe_en;
    logic [2:0] clk_sel;
    tip_cond_t cond_mode;
    logic open_drain;
    logic out_dir;
    logic enable;
  } tip_port_cfg_t;
endpackage

/* sim/tb.sv */
// self-checking bench for the timed i/o port block
// assumes tip_port_top, tip_pin_model and the bound checker are compiled first
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] addr = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] link_o = 32'h0;
  logic [31:0] link_oe = 32'h0;
  logic [31:0] ext = 32'h0;
  logic [31:0] ext_en = 32'h0;
  logic stall = 1'b0;
  logic [31:0] rdata, pin_i, pin_o, pin_oe, pd, last_rd, d1, d2;
  logic wait_o;
  logic [4:0] ready, strobe, event_v;
  logic [63:0] rq[$];
  logic [63:0] rexp;
  logic [3:0] pq[$];
  logic [3:0] pw_last, pw_exp;
  logic pw_on = 1'b0;
  logic pw_od = 1'b0;
  logic pw_stb = 1'b0;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int unsigned seed;

  initial forever #4 clk = ~clk;

  tip_port_top u_tip_port_top (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_o), .PIN_I(pin_i), .PIN_O(pin_o),
    .PIN_OE_O(pin_oe), .PULLDOWN_O(pd), .LINK_O_I(link_o), .LINK_OE_I(link_oe),
    .READY_I(ready), .STROBE_OUT_O(strobe), .EVENT_O(event_v)
  );
  tip_pin_model u_tip_pin_model (
    .clk_i(clk), .rst_n_i(rst_n), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pulldown_i(pd),
    .ext_i(ext), .ext_en_i(ext_en), .stall_i(stall), .lvl_o(pin_i), .ready_o(ready)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // one bus cycle; a read notes its masked expectation for the monitor
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e);
    if (!w) rq.push_back({m, e});
    @(posedge clk);
    addr <= a;
    wdata <= d;
    if (w) wr <= 1'b1;
    else rd <= 1'b1;
    do @(posedge clk); while (wait_o !== 1'b0);
    last_rd = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function automatic logic [9:0] ra(input int p, input logic [2:0] r);
    return 10'(p * tip_pkg::PORT_STRIDE) + {5'h0, r, 2'b00};
  endfunction
  function automatic logic [3:0] vnow();
    return pw_od ? ~pin_oe[3:0] : pin_o[3:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (rd && wait_o === 1'b0 && rq.size() > 0) begin
      rexp = rq.pop_front();
      check(rdata & rexp[63:32], rexp[31:0]);
    end
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // every change on the 4-bit port's pins must be the next expected slice
  always @(posedge clk) begin
    if (pw_on && vnow() !== pw_last) begin
      if (pq.size() == 8) check({31'h0, event_v[1]}, 32'h1);
      pw_exp = (pq.size() > 0) ? pq.pop_front() : ~vnow();
      check({28'h0, vnow()}, {28'h0, pw_exp});
      if (pw_od) check({28'h0, pin_o[3:0]}, 32'h0);
      if (pw_stb) check({31'h0, strobe[1]}, 32'h1);
      pw_last = vnow();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic out_word(input logic od, input logic stb);
    logic [31:0] w;
    logic [3:0] n;
    logic [15:0] t;
    pw_on = 1'b0;
    stall <= stb;
    acc(1'b1, ra(1, tip_pkg::REG_CTRL), {23'h0, stb, 5'h0, od, 2'b11}, 0, 0);
    @(negedge clk);
    pw_od = od;
    pw_stb = stb;
    pw_last = vnow();
    pw_on = 1'b1;
    n = pw_last;
    for (int i = 0; i < 8; i++) begin
      n = n + 4'(1 + $urandom % 15);
      w[4*i +: 4] = n;
      pq.push_back(n);
    end
    if (!stb) begin
      acc(1'b0, ra(1, tip_pkg::REG_COUNT), 32'h0, 32'h0, 32'h0);
      t = last_rd[15:0] + 16'h0040;
      acc(1'b1, ra(1, tip_pkg::REG_TIME), {16'h0, t}, 0, 0);
    end
    acc(1'b1, ra(1, tip_pkg::REG_DATA), w, 0, 0);
    if (stb) begin
      repeat (100) @(posedge clk);
      check(32'(pq.size()), 32'h8);
      stall <= 1'b0;
    end
    while (pq.size() > 0) @(posedge clk);
    repeat (30) @(posedge clk);
    if (!stb) begin
      acc(1'b0, ra(1, tip_pkg::REG_TSTAMP), 32'h0, 32'h0000_FFFF, {16'h0, t});
      acc(1'b0, ra(1, tip_pkg::REG_STAT), 32'h0, 32'h0001_0000, 32'h0);
    end
  endtask
  task automatic in_word(input int p, input logic [1:0] mode);
    logic [31:0] msk, a, b, e;
    msk = (p == 2) ? 32'h0000_00FF : 32'h0000_FFFF;
    a = $urandom & msk;
    b = a ^ (($urandom % msk) + 32'h1);
    e = 32'h0;
    for (int i = 0; i < 32; i += (p == 2) ? 8 : 16) e = e | (b << i);
    ext <= a;
    ext_en <= msk;
    acc(1'b1, ra(p - 1, tip_pkg::REG_CTRL), 32'h0, 0, 0);
    acc(1'b1, ra(p, tip_pkg::REG_COND), (mode == 2'h1) ? b : a, 0, 0);
    acc(1'b1, ra(p, tip_pkg::REG_CTRL), {27'h0, mode, 3'b001}, 0, 0);
    repeat (40) @(negedge clk);
    check(pin_oe & msk, 32'h0);
    acc(1'b0, ra(p, tip_pkg::REG_STAT), 32'h0, 32'h0000_0001, 32'h0);
    ext <= b;
    acc(1'b0, ra(p, tip_pkg::REG_DATA), 32'h0, 32'hFFFF_FFFF, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(17);
    repeat (2) @(negedge clk);
    check(pd, 32'hFFFF_FFFF);
    check(pin_oe, 32'h0);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    check(pd, 32'h0);
    for (int p = 0; p < 5; p++) begin
      acc(1'b0, ra(p, tip_pkg::REG_CTRL), 32'h0, 32'hFFFF_FFFF, tip_pkg::CTRL_RESET);
    end
    d1 = {16'h0, 8'($urandom), 8'h03};
    acc(1'b1, tip_pkg::CLK_BASE + 10'h004, d1, 0, 0);
    acc(1'b0, tip_pkg::CLK_BASE + 10'h004, 32'h0, 32'h0000_FF03, d1);
    acc(1'b1, 10'h0E0, $urandom, 0, 0);
    acc(1'b0, 10'h0E0, 32'h0, 32'hFFFF_FFFF, 32'h0);
    acc(1'b0, 10'h300, 32'h0, 32'hFFFF_FFFF, 32'h0);
    out_word(1'b0, 1'b0);
    out_word(1'b1, 1'b1);
    pw_on = 1'b0;
    in_word(2, 2'h1);
    in_word(3, 2'h2);
    // narrower port keeps pins 3:0, wider port keeps its unshared pins 7:4
    acc(1'b1, ra(3, tip_pkg::REG_CTRL), 32'h0, 0, 0);
    d2 = $urandom;
    d1 = $urandom;
    acc(1'b1, ra(2, tip_pkg::REG_CTRL), 32'h3, 0, 0);
    acc(1'b1, ra(2, tip_pkg::REG_DATA), d2, 0, 0);
    acc(1'b1, ra(1, tip_pkg::REG_CTRL), 32'h3, 0, 0);
    acc(1'b1, ra(1, tip_pkg::REG_DATA), d1, 0, 0);
    repeat (60) @(negedge clk);
    check(pin_o & 32'hFF, {24'h0, d2[31:28], d1[31:28]});
    check(pin_oe & 32'hFF, 32'hFF);
    @(posedge clk);
    link_o <= $urandom;
    link_oe <= $urandom;
    acc(1'b1, tip_pkg::LINK_CTRL, 32'h1, 0, 0);
    repeat (3) @(negedge clk);
    check(pin_oe & tip_pkg::LINK_PIN_MASK, link_oe & tip_pkg::LINK_PIN_MASK);
    check({28'h0, pin_o[3:0]}, {28'h0, d1[31:28]});
    acc(1'b1, tip_pkg::LINK_CTRL, 32'h0, 0, 0);
    repeat (5) @(posedge clk);
    stop_test();
  end
endmodule

/* sim/tip_pin_model.sv */
// external hardware on the pins: resolves each wire and drives ready strobes
// assumes the bench chooses which pins it drives and at what level
`timescale 1ns/100ps
module tip_pin_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] pin_o_i,
  input wire logic [31:0] pin_oe_i,
  input wire logic [31:0] pulldown_i,
  input wire logic [31:0] ext_i,
  input wire logic [31:0] ext_en_i,
  input wire logic stall_i,
  output logic [31:0] lvl_o,
  output logic [4:0] ready_o
);
  logic [31:0] pat_q;
  logic [31:0] far;
  // undriven pins toggle so a stale level never passes as data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pat_q <= 32'h0;
    end else begin
      pat_q <= ~pat_q;
    end
  end
  assign far = (ext_en_i & ext_i) | (~ext_en_i & pat_q);
  assign lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ~pulldown_i & far);
  assign ready_o = {5{~stall_i}};
endmodule

/* sim/tip_port_top_assertions.sv */
// checker for the timed i/o port top: bus answers, reset pulls, link takeover
// assumes it is bound to tip_port_top and that byte enables are all set
`timescale 1ns/100ps
module tip_chk (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic [9:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic [31:0] PIN_O,
  input wire logic [31:0] PIN_OE_O,
  input wire logic [31:0] PULLDOWN_O,
  input wire logic [31:0] LINK_O_I,
  input wire logic [31:0] LINK_OE_I,
  input wire logic [4:0] EVENT_O
);
  logic link_q;
  logic ctrl_wr_q;
  logic wr_ok;
  logic req;
  logic unm;
  logic is_ctrl;
  ////////////////////////////////////////////////////////////////////////////
  assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign req = AVS_READ_I || AVS_WRITE_I;
  assign is_ctrl = AVS_ADDRESS_I[9:8] == tip_pkg::REGION_PORT &&
    AVS_ADDRESS_I[4:2] == tip_pkg::REG_CTRL;
  assign unm = AVS_ADDRESS_I[9:8] == 2'h3 || (AVS_ADDRESS_I[9:8] == tip_pkg::REGION_PORT &&
    (AVS_ADDRESS_I[7:5] > 3'h4 || AVS_ADDRESS_I[4:2] == 3'h7));
  // mirror of link enable and of any port control write
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      link_q <= 1'b0;
    end else if (wr_ok && AVS_ADDRESS_I[9:2] == tip_pkg::LINK_CTRL[9:2]) begin
      link_q <= AVS_WRITEDATA_I[0];
    end
  end
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctrl_wr_q <= 1'b0;
    end else if (wr_ok && is_ctrl) begin
      ctrl_wr_q <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);
  property p_pd_release;
    $rose(RESET_N_I) |-> PULLDOWN_O == 32'hFFFF_FFFF ##1 PULLDOWN_O == 32'h0;
  endproperty
  a_pd_release: assert property (p_pd_release) else $error("pull-downs wrong at release");
  property p_pd_run;
    $past(RESET_N_I) |-> PULLDOWN_O == 32'h0;
  endproperty
  a_pd_run: assert property (p_pd_run) else $error("pull-downs on outside reset");
  property p_wait_idle;
    !req |-> !AVS_WAITREQUEST_O;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest without request");
  property p_ack_fast;
    $rose(req) && AVS_ADDRESS_I[4:2] != tip_pkg::REG_DATA
      |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O;
  endproperty
  a_ack_fast: assert property (p_ack_fast) else $error("register answer not in two cycles");
  property p_unmapped;
    $rose(AVS_READ_I) && unm |-> ##1 AVS_READDATA_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_clk0_reset;
    $rose(AVS_READ_I) && is_ctrl && !ctrl_wr_q |-> ##1 AVS_READDATA_O[7:5] == 3'h0;
  endproperty
  a_clk0_reset: assert property (p_clk0_reset) else $error("port not on clock block 0");
  property p_link;
    link_q |-> ((PIN_O ^ LINK_O_I) & LINK_OE_I & tip_pkg::LINK_PIN_MASK) == 32'h0 &&
      ((PIN_OE_O ^ LINK_OE_I) & tip_pkg::LINK_PIN_MASK) == 32'h0;
  endproperty
  a_link: assert property (p_link) else $error("link pins not handed to link");
  property p_event;
    |EVENT_O |=> (EVENT_O & $past(EVENT_O) & $past(EVENT_O, 2)) == 5'h0;
  endproperty
  a_event: assert property (p_event) else $error("event on three cycles running");
endmodule

bind tip_port_top tip_chk u_tip_chk (
  .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PIN_O(PIN_O),
  .PIN_OE_O(PIN_OE_O), .PULLDOWN_O(PULLDOWN_O), .LINK_O_I(LINK_O_I),
  .LINK_OE_I(LINK_OE_I), .EVENT_O(EVENT_O)
);
